// [hdl/ppol_regs.vh]
// Notes on behaviour
// - Sleep clamp grounds digital input before trigger
// - Enabled external interrupt pin escapes the clamp
// - Clamp release sets any-change flag on high
// - Pull-up: forced value, else dir/drive/kill 010
// - Forced pull-up ignores register bits
// - Driver enable from forced value or direction
// - Forced driver enable ignores direction bit
// - Driven level from forced value or drive
// - Forced value ignores drive bit entirely
// - Input enable forced, else by sleep state
// - Forced input enable ignores sleep state
// - Alternate input raw after trigger, unsynchronised
// - Analog path wired straight to pad
// - Kill bit two disables every unforced pull-up
// - Port strobes per port, clamp/kill global
// - Direction one is output, zero input
// - Drive bit: pull-up on input, level on output
// - Pin value through two-stage synchroniser
// - Reset tri-states pins immediately, clockless
`ifndef PPOL_REGS_VH
`define PPOL_REGS_VH
`define PPOL_ADDR_DIR 4'h0
`define PPOL_ADDR_DRIVE 4'h4
`define PPOL_ADDR_PIN 4'h8
`define PPOL_ADDR_SFIO 4'hc
`define PPOL_ADDR_FLAG 4'h0
`define PPOL_SFIO_KILL_BIT 2
`define PPOL_SFIO_RESET 8'h00
`endif

// [hdl/ppol_port.v]
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`include "ppol_regs.vh"
module ppol_port #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sleep_clamp_i,
  input wire [WIDTH-1:0] ext_int_en_i,
  input wire [WIDTH-1:0] ext_int_any_i,
  output reg [WIDTH-1:0] ext_int_flag_o,
  input wire [WIDTH-1:0] ext_int_flag_clr_i,
  input wire [WIDTH-1:0] pullup_force_en_i,
  input wire [WIDTH-1:0] pullup_force_val_i,
  input wire [WIDTH-1:0] dir_force_en_i,
  input wire [WIDTH-1:0] dir_force_val_i,
  input wire [WIDTH-1:0] value_force_en_i,
  input wire [WIDTH-1:0] value_force_val_i,
  input wire [WIDTH-1:0] input_en_force_en_i,
  input wire [WIDTH-1:0] input_en_force_val_i,
  output wire [WIDTH-1:0] alt_fn_sense_input_o,
  input wire [WIDTH-1:0] pad_i,
  output wire [WIDTH-1:0] pad_o,
  output wire [WIDTH-1:0] pad_oe_o,
  output wire [WIDTH-1:0] pad_pullup_o,
  output wire [WIDTH-1:0] alt_fn_pad_analog_o
);
  // Software-visible pin configuration
  reg [WIDTH-1:0] pin_dir_bit;
  reg [WIDTH-1:0] pin_drive_bit;
  reg [7:0] special_function_io;

  // Clamped pin path, two flops behind the trigger
  reg [WIDTH-1:0] sync_a;
  reg [WIDTH-1:0] pin_sync_bit;

  // Raw pad path, synchronised for the wake flags
  reg [WIDTH-1:0] pad_meta;
  reg [WIDTH-1:0] pad_sync;

  // Sleep clamp as sampled one cycle earlier
  reg clamp_q;

  // Next values and write strobes
  reg [31:0] next_dat;
  reg [WIDTH-1:0] next_flag;
  reg wr_dir;
  reg wr_drive;
  reg wr_sfio;

  // Shared controls
  wire global_pullup_kill;
  wire clamp_fall;
  wire [WIDTH-1:0] run_mask;

  // Bus qualifiers
  wire bus_req;
  wire wr_strobe;
  wire rd_strobe;
  wire [WIDTH-1:0] wide_dat;

  // Read-back words, upper bits zero
  wire [31:0] dir_word;
  wire [31:0] drive_word;
  wire [31:0] pin_word;
  wire [31:0] sfio_word;

  // Per-pin results
  wire [WIDTH-1:0] clamp_act;
  wire [WIDTH-1:0] in_en;
  wire [WIDTH-1:0] trig;
  wire [WIDTH-1:0] drv_en;
  wire [WIDTH-1:0] drv_val;
  wire [WIDTH-1:0] pu_def;
  wire [WIDTH-1:0] pu_en;
  wire [WIDTH-1:0] wake_cand;
  wire [WIDTH-1:0] wake_set;

  // Kill bit, clamp and reset are common to every pin
  assign global_pullup_kill = special_function_io[`PPOL_SFIO_KILL_BIT];
  assign clamp_fall = clamp_q & ~sleep_clamp_i;
  assign run_mask = {WIDTH{~rst_i}};

  // A standing ack blocks a second take of the same request
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_strobe = bus_req & wb_we_i & wb_sel_i[0];
  assign rd_strobe = bus_req & ~wb_we_i;
  // Only the low WIDTH bits carry pin data
  assign wide_dat = wb_dat_i[WIDTH-1:0];

  assign dir_word = {{(32-WIDTH){1'b0}}, pin_dir_bit};
  assign drive_word = {{(32-WIDTH){1'b0}}, pin_drive_bit};
  assign pin_word = {{(32-WIDTH){1'b0}}, pin_sync_bit};
  assign sfio_word = {24'h00_0000, special_function_io};

  genvar n;

  // One slice of override logic per pin
  generate
    for (n = 0; n < WIDTH; n = n + 1) begin : pin_logic
      // Clamp spares pins with an enabled external interrupt
      assign clamp_act[n] = sleep_clamp_i & ~ext_int_en_i[n];
      // Peripheral override beats the sleep state
      assign in_en[n] = input_en_force_en_i[n] ?
                        input_en_force_val_i[n] :
                        ~clamp_act[n];
      // Disabled input is grounded ahead of the trigger
      assign trig[n] = pad_i[n] & in_en[n];
      // Output driver enable
      assign drv_en[n] = dir_force_en_i[n] ?
                         dir_force_val_i[n] :
                         pin_dir_bit[n];
      // Driven level, only seen while the driver is on
      assign drv_val[n] = value_force_en_i[n] ?
                          value_force_val_i[n] :
                          pin_drive_bit[n];
      // Register pull-up: input pin, drive bit set, no kill
      assign pu_def[n] = ~pin_dir_bit[n] & pin_drive_bit[n] & ~global_pullup_kill;
      // Peripheral pull-up override
      assign pu_en[n] = pullup_force_en_i[n] ?
                        pullup_force_val_i[n] :
                        pu_def[n];
      // High pin, any-change sensing, interrupt masked
      assign wake_cand[n] = ext_int_any_i[n] & ~ext_int_en_i[n] & pad_sync[n];
      // Clamp release counts as the requested change
      assign wake_set[n] = wake_cand[n] & clamp_fall;
    end
  endgenerate

  // Reset acts combinationally so pads float with no clock
  assign pad_oe_o = drv_en & run_mask;
  // Level is ignored by the pad unless enabled
  assign pad_o = drv_val & run_mask;
  assign pad_pullup_o = pu_en & run_mask;

  // Raw after the trigger; users add their own synchroniser
  assign alt_fn_sense_input_o = trig;
  // Straight wire from the pad input, one direction only
  assign alt_fn_pad_analog_o = pad_i;

  // Write decode; sel bit 0 qualifies every write
  always @* begin
    wr_dir = 1'b0;
    wr_drive = 1'b0;
    wr_sfio = 1'b0;
    if (wr_strobe) begin
      case (wb_adr_i)
        `PPOL_ADDR_DIR: begin
          wr_dir = 1'b1;
        end
        `PPOL_ADDR_DRIVE: begin
          wr_drive = 1'b1;
        end
        `PPOL_ADDR_SFIO: begin
          wr_sfio = 1'b1;
        end
        // Pin register is read only
        default: begin
          wr_dir = 1'b0;
        end
      endcase
    end
  end

  // Direction register, one means output
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_dir_bit <= {WIDTH{1'b0}};
    end else if (ce_i && wr_dir) begin
      pin_dir_bit <= wide_dat;
    end
  end

  // Drive register: pull-up on input, level on output
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_drive_bit <= {WIDTH{1'b0}};
    end else if (ce_i && wr_drive) begin
      pin_drive_bit <= wide_dat;
    end
  end

  // Special function register; bit 2 kills every unforced pull-up
  always @(posedge clk_i) begin
    if (rst_i) begin
      special_function_io <= `PPOL_SFIO_RESET;
    end else if (ce_i && wr_sfio) begin
      special_function_io <= wb_dat_i[7:0];
    end
  end

  // Ack one cycle after the take, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
    end
  end

  // Read mux; only a taken read loads data
  always @* begin
    next_dat = 32'h0000_0000;
    if (rd_strobe) begin
      case (wb_adr_i)
        `PPOL_ADDR_DIR: begin
          next_dat = dir_word;
        end
        `PPOL_ADDR_DRIVE: begin
          next_dat = drive_word;
        end
        `PPOL_ADDR_PIN: begin
          next_dat = pin_word;
        end
        `PPOL_ADDR_SFIO: begin
          next_dat = sfio_word;
        end
        // Unmapped offsets read zero
        default: begin
          next_dat = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data stands for the ack cycle only
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_dat_o <= next_dat;
    end
  end

  // Clamped path, first flop, read only by the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      sync_a <= trig;
    end
  end

  // Clamped path, second flop
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_sync_bit <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      pin_sync_bit <= sync_a;
    end
  end

  // Raw pad, first flop, read only by the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      pad_meta <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      pad_meta <= pad_i;
    end
  end

  // Raw pad, second flop
  always @(posedge clk_i) begin
    if (rst_i) begin
      pad_sync <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      pad_sync <= pad_meta;
    end
  end

  // Clamp delay for release detection
  always @(posedge clk_i) begin
    if (rst_i) begin
      clamp_q <= 1'b0;
    end else if (ce_i) begin
      clamp_q <= sleep_clamp_i;
    end
  end

  // Set beats a clear in the same cycle
  always @* begin
    next_flag = ext_int_flag_o & ~ext_int_flag_clr_i;
    next_flag = next_flag | wake_set;
  end

  // Sticky wake flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_int_flag_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      ext_int_flag_o <= next_flag;
    end
  end
endmodule // ppol_port

// [sim/ppol_port_sva.sv]
module ppol_port_sva #(parameter WIDTH = 8) (
  input wire clk_i, rst_i, ce_i, sleep_clamp_i,
  input wire [WIDTH-1:0] ext_int_en_i, ext_int_any_i, ext_int_flag_o, pad_i, pad_oe_o, pad_pullup_o,
  input wire [WIDTH-1:0] pullup_force_en_i, pullup_force_val_i, dir_force_en_i, dir_force_val_i,
  input wire [WIDTH-1:0] input_en_force_en_i, input_en_force_val_i, alt_fn_sense_input_o, alt_fn_pad_analog_o,
  input wire [WIDTH-1:0] pad_o, value_force_en_i, value_force_val_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_dir_forced: assert property ((pad_oe_o & dir_force_en_i) == (dir_force_val_i & dir_force_en_i))
    else $error("forced oe");
  chk_pull_forced: assert property ((pad_pullup_o & pullup_force_en_i) == (pullup_force_val_i & pullup_force_en_i))
    else $error("forced pull");
  chk_pull_on_out: assert property ((pad_pullup_o & pad_oe_o & ~pullup_force_en_i & ~dir_force_en_i) == 0)
    else $error("pull on output");
  chk_analog_path: assert property (alt_fn_pad_analog_o == pad_i)
    else $error("analog");
  chk_clamp_zero: assert property ((alt_fn_sense_input_o & ~input_en_force_en_i & ~ext_int_en_i) == 0 || !sleep_clamp_i)
    else $error("clamp");
  chk_input_forced: assert property ((alt_fn_sense_input_o & input_en_force_en_i) == (pad_i & input_en_force_en_i & input_en_force_val_i))
    else $error("forced input");
  chk_wake_flag: assert property (ce_i && $fell(sleep_clamp_i) && $past(pad_i[WIDTH-1], 2) && ext_int_any_i[WIDTH-1] && !ext_int_en_i[WIDTH-1] |=> ext_int_flag_o[WIDTH-1])
    else $error("wake flag");
  chk_value_forced: assert property ((pad_o & pad_oe_o & value_force_en_i) == (value_force_val_i & pad_oe_o & value_force_en_i))
    else $error("forced value");
  chk_reset_tristate: assert property (disable iff (1'b0) rst_i |-> (pad_oe_o | pad_pullup_o) == 0)
    else $error("reset pads");
  cover property ($fell(sleep_clamp_i));
  cover property (|(dir_force_en_i & pad_oe_o));
  cover property (|(input_en_force_en_i & alt_fn_sense_input_o));
endmodule // ppol_port_sva
bind ppol_port ppol_port_sva #(.WIDTH(WIDTH)) ppol_port_sva_inst (.*);

// [sim/ppol_pad_model.sv]
module ppol_pad_model (input wire clk_i, input wire [7:0] drv_i, oe_i, pu_i, ext_i, ext_en_i, output logic [7:0] pad_o);
  timeunit 1ns; timeprecision 1ns;
  logic [7:0] last = '0;
  always @(posedge clk_i) last <= pad_o;
  // Undriven bit shows external level if enabled, else pull-up, else inverse of last level
  assign pad_o = oe_i & drv_i | ~oe_i & (ext_en_i & ext_i | ~ext_en_i & (pu_i | ~last));
endmodule // ppol_pad_model

// [sim/ppol_port_bench.sv]
`define C(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("BAD %0t mismatch", $time); end end
module ppol_port_bench;
  timeunit 1ns; timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, sleep_clamp_i = 0;
  logic [3:0] wb_adr_i = '0, wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = '0;
  logic [7:0] ext_int_en_i = '0, ext_int_any_i = '0, ext_int_flag_clr_i = '0, xv = '0, xe = '0;
  logic [7:0] pullup_force_en_i = '0, pullup_force_val_i = '0, dir_force_en_i = '0, dir_force_val_i = '0;
  logic [7:0] value_force_en_i = '0, value_force_val_i = '0, input_en_force_en_i = '0, input_en_force_val_i = '0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [7:0] ext_int_flag_o, alt_fn_sense_input_o, pad_i, pad_o, pad_oe_o, pad_pullup_o, alt_fn_pad_analog_o;
  int err_count = 0, comparisons = 0, cyc_n = 0;
  ppol_port ppol_port_inst (.*);
  ppol_pad_model ppol_pad_model_inst (.clk_i, .drv_i(pad_o), .oe_i(pad_oe_o), .pu_i(pad_pullup_o), .ext_i(xv),
    .ext_en_i(xe), .pad_o(pad_i));
  initial forever #50 clk_i = ~clk_i;
  task complete_run;
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) if (++cyc_n > 2000) begin err_count++; complete_run(); end
  task rw(input logic w, input logic [3:0] a, input logic [31:0] d, e);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (!w) `C(wb_dat_o, e)
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    `C(pad_oe_o | pad_pullup_o, 8'h00)
    rst_i <= 0;
    rw(1, 4'h0, 32'h0000_000F, 0);
    rw(1, 4'h4, 32'h0000_00F5, 0);
    `C({pad_oe_o, pad_o & pad_oe_o, pad_pullup_o}, 24'h0F_05F0)
    rw(1, 4'hC, 32'h0000_0004, 0);
    rw(0, 4'hC, 0, 32'h0000_0004);
    `C(pad_pullup_o, 8'h00)
    rw(0, 4'h2, 0, 0);
    wb_sel_i <= 4'h0;
    rw(1, 4'h0, 32'h0000_00FF, 0);
    wb_sel_i <= 4'h1;
    rw(0, 4'h0, 0, 32'h0000_000F);
    rw(1, 4'hC, 0, 0);
    {pullup_force_en_i, pullup_force_val_i, dir_force_en_i, dir_force_val_i, value_force_en_i,
      value_force_val_i} <= 48'hFF3C_FFAA_FF0F;
    @(posedge clk_i);
    `C({pad_oe_o, pad_o & pad_oe_o, pad_pullup_o}, 24'hAA_0A3C)
    {pullup_force_en_i, pullup_force_val_i, dir_force_en_i, dir_force_val_i, value_force_en_i} <= '0;
    {xv, xe} <= 16'hA0F0;
    repeat (3) @(posedge clk_i);
    rw(0, 4'h8, 0, 32'h0000_00A5);
    `C(alt_fn_pad_analog_o, 8'hA5)
    {sleep_clamp_i, ext_int_en_i, ext_int_any_i} <= 17'h1_0180;
    repeat (3) @(posedge clk_i);
    `C(alt_fn_sense_input_o, 8'h01)
    rw(0, 4'h8, 0, 32'h0000_0001);
    {input_en_force_en_i, input_en_force_val_i} <= 16'h0404;
    @(posedge clk_i);
    `C(alt_fn_sense_input_o, 8'h05)
    sleep_clamp_i <= 0;
    repeat (2) @(posedge clk_i);
    `C(ext_int_flag_o, 8'h80)
    {ce_i, ext_int_flag_clr_i} <= 9'h0FF;
    repeat (2) @(posedge clk_i);
    `C(ext_int_flag_o, 8'h80)
    ce_i <= 1;
    repeat (2) @(posedge clk_i);
    `C(ext_int_flag_o, 8'h00)
    sleep_clamp_i <= 1;
    @(posedge clk_i);
    sleep_clamp_i <= 0;
    repeat (2) @(posedge clk_i);
    `C(ext_int_flag_o, 8'h80)
    complete_run();
  end
endmodule // ppol_port_bench
